/* File: rtl/tcp_pkg.sv */
// package: register map, field layout, modes and state for the capture/compare block
package tcp_pkg;
  // ==========================================================
  // register byte offsets on the avalon slave
  localparam logic [5:0] OFF_CAP_CTRL = 6'h00;
  localparam logic [5:0] OFF_CAP_BUF = 6'h04;
  localparam logic [5:0] OFF_CMP_CTRL = 6'h08;
  localparam logic [5:0] OFF_CMP_PRI = 6'h0c;
  localparam logic [5:0] OFF_CMP_SEC = 6'h10;
  localparam logic [5:0] OFF_IRQ = 6'h14;
  localparam logic [5:0] OFF_TB_A_CNT = 6'h18;
  localparam logic [5:0] OFF_TB_A_PER = 6'h1c;
  localparam logic [5:0] OFF_TB_B_CNT = 6'h20;
  localparam logic [5:0] OFF_TB_B_PER = 6'h24;
  localparam logic [5:0] OFF_TB_RUN = 6'h28;
  // ==========================================================
  // field positions
  localparam int CAP_IDLE_BIT = 13;
  localparam int CAP_TB_BIT = 7;
  localparam int CAP_IPI_LSB = 5;
  localparam int CAP_OV_BIT = 4;
  localparam int CAP_BNE_BIT = 3;
  localparam int CMP_IDLE_BIT = 13;
  localparam int CMP_TB_BIT = 3;
  localparam int IRQ_CAP_FLAG_BIT = 0;
  localparam int IRQ_CMP_FLAG_BIT = 1;
  localparam int IRQ_CAP_EN_BIT = 8;
  localparam int IRQ_CMP_EN_BIT = 9;
  // ==========================================================
  // mode codes
  localparam logic [2:0] CAP_OFF = 3'h0;
  localparam logic [2:0] CAP_BOTH = 3'h1;
  localparam logic [2:0] CAP_FALL = 3'h2;
  localparam logic [2:0] CAP_RISE = 3'h3;
  localparam logic [2:0] CAP_RISE4 = 3'h4;
  localparam logic [2:0] CAP_RISE16 = 3'h5;
  localparam logic [2:0] CAP_UNUSED = 3'h6;
  localparam logic [2:0] CAP_WAKE = 3'h7;
  localparam logic [2:0] CMP_ONESHOT = 3'h4;
  localparam logic [2:0] CMP_CONT = 3'h5;
  localparam logic [3:0] PRESCALE4_LAST = 4'h3;
  localparam logic [3:0] PRESCALE16_LAST = 4'hf;
  localparam logic [2:0] FIFO_DEPTH = 3'h4;
  localparam logic [15:0] RESET_VALUE = 16'h0000;
  // ==========================================================
  // carriers and state
  typedef struct packed {
    logic read;
    logic write;
    logic [5:0] address;
    logic [31:0] writedata;
  } tcp_avm_req_t;
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } tcp_avm_rsp_t;
  typedef enum logic [1:0] {CMP_IDLE, CMP_WAIT_RISE, CMP_WAIT_FALL, CMP_DONE} tcp_cmp_state_t;
  typedef struct packed {
    logic wait_q;
    logic [31:0] rdata;
    logic pop_ok;
    logic [1:0][15:0] tb_cnt;
    logic [1:0][15:0] tb_per;
    logic [1:0] tb_run;
    logic [2:0] sync;
    logic filt;
    logic cap_idle;
    logic cap_tb;
    logic [1:0] cap_ipi;
    logic [2:0] cap_mode;
    logic cap_ov;
    logic [3:0][15:0] fifo;
    logic [1:0] rd_ptr;
    logic [2:0] fifo_cnt;
    logic [3:0] pre_cnt;
    logic [1:0] ipi_cnt;
    logic cmp_idle;
    logic cmp_tb;
    logic [2:0] cmp_mode;
    logic [15:0] cmp_pri;
    logic [15:0] cmp_sec;
    tcp_cmp_state_t cmp_st;
    logic pin;
    logic [1:0] flag;
    logic [1:0] en;
    logic [1:0] irq;
  } tcp_state_t;
endpackage : tcp_pkg

/* File: rtl/tcp_top.sv */
// top: input capture channel, pulse compare channel, two timebases, avalon slave
//
// The implementer's own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/10ps
module tcp_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  input wire logic capture_input_pin,
  input wire tcp_pkg::tcp_avm_req_t avm_req,
  output tcp_pkg::tcp_avm_rsp_t avm_rsp,
  output logic compare_output_pin,
  output logic capture_irq,
  output logic compare_irq
);
  import tcp_pkg::*;

  function automatic logic [15:0] tb_pick(input logic pick_a, input logic [1:0][15:0] cnt);
    tb_pick = pick_a ? cnt[0] : cnt[1];
  endfunction : tb_pick

  function automatic logic tb_ticking(input logic pick_a, input logic [1:0] run);
    tb_ticking = pick_a ? run[0] : run[1];
  endfunction : tb_ticking

  tcp_state_t q;
  tcp_state_t n;
  logic req;
  logic acc;
  logic wr;
  logic rd;
  logic rise;
  logic fall;
  logic ev;
  logic fire;
  logic pop;
  logic cap_run;
  logic cmp_run;
  logic cmp_pick_a;
  logic [15:0] cmp_cnt;
  logic [1:0] flag_set;
  logic [1:0] flag_clr;

  // ==========================================================
  // next state
  always_comb begin
    n = q;
    flag_set = 2'b00;
    flag_clr = 2'b00;
    ev = 1'b0;
    fire = 1'b0;
    // one wait cycle, then the request is taken at the edge with waitrequest low
    req = avm_req.read | avm_req.write;
    acc = req & ~q.wait_q;
    wr = acc & avm_req.write;
    rd = acc & avm_req.read;
    n.wait_q = ~(req & q.wait_q);
    if (req && q.wait_q) begin
      n.rdata = 32'h0000_0000;
      n.pop_ok = 1'b0;
      case (avm_req.address)
        OFF_CAP_CTRL: begin
          n.rdata[CAP_IDLE_BIT] = q.cap_idle;
          n.rdata[CAP_TB_BIT] = q.cap_tb;
          n.rdata[CAP_IPI_LSB +: 2] = q.cap_ipi;
          n.rdata[CAP_OV_BIT] = q.cap_ov;
          n.rdata[CAP_BNE_BIT] = (q.fifo_cnt != 3'h0);
          n.rdata[2:0] = q.cap_mode;
        end
        OFF_CAP_BUF: begin
          n.rdata[15:0] = q.fifo[q.rd_ptr];
          n.pop_ok = (q.fifo_cnt != 3'h0);
        end
        OFF_CMP_CTRL: begin
          n.rdata[CMP_IDLE_BIT] = q.cmp_idle;
          n.rdata[CMP_TB_BIT] = q.cmp_tb;
          n.rdata[2:0] = q.cmp_mode;
        end
        OFF_CMP_PRI: n.rdata[15:0] = q.cmp_pri;
        OFF_CMP_SEC: n.rdata[15:0] = q.cmp_sec;
        OFF_IRQ: begin
          n.rdata[IRQ_CAP_FLAG_BIT +: 2] = q.flag;
          n.rdata[IRQ_CAP_EN_BIT +: 2] = q.en;
        end
        OFF_TB_A_CNT: n.rdata[15:0] = q.tb_cnt[0];
        OFF_TB_A_PER: n.rdata[15:0] = q.tb_per[0];
        OFF_TB_B_CNT: n.rdata[15:0] = q.tb_cnt[1];
        OFF_TB_B_PER: n.rdata[15:0] = q.tb_per[1];
        OFF_TB_RUN: n.rdata[1:0] = q.tb_run;
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    // timebases
    for (int i = 0; i < 2; i++) begin
      if (q.tb_run[i]) begin
        n.tb_cnt[i] = (q.tb_cnt[i] == q.tb_per[i]) ?
          RESET_VALUE : q.tb_cnt[i] + 16'h0001;
      end
    end
    // ==========================================================
    // capture input: three stages, a change counts when stages two and three agree
    n.sync = {q.sync[1:0], capture_input_pin};
    if (q.sync[1] == q.sync[2]) begin
      n.filt = q.sync[2];
    end
    rise = (q.sync[1] == q.sync[2]) & q.sync[2] & ~q.filt;
    fall = (q.sync[1] == q.sync[2]) & ~q.sync[2] & q.filt;
    cap_run = ~(q.cap_idle & cpu_idle);
    if (q.cap_mode == CAP_WAKE) begin
      if (rise && (cpu_idle || cpu_sleep)) begin
        flag_set[IRQ_CAP_FLAG_BIT] = 1'b1;
      end
    end else if (cap_run) begin
      case (q.cap_mode)
        CAP_BOTH: ev = rise | fall;
        CAP_FALL: ev = fall;
        CAP_RISE: ev = rise;
        CAP_RISE4: begin
          ev = rise & (q.pre_cnt[1:0] == PRESCALE4_LAST[1:0]);
          n.pre_cnt = rise ? {2'b00, q.pre_cnt[1:0] + 2'b01} : q.pre_cnt;
        end
        CAP_RISE16: begin
          ev = rise & (q.pre_cnt == PRESCALE16_LAST);
          n.pre_cnt = rise ? q.pre_cnt + 4'h1 : q.pre_cnt;
        end
        default: ev = 1'b0;
      endcase
      if (ev) begin
        if (q.fifo_cnt == FIFO_DEPTH) begin
          n.cap_ov = 1'b1;
        end else begin
          n.fifo[q.rd_ptr + q.fifo_cnt[1:0]] =
            tb_pick(q.cap_tb, q.tb_cnt);
          n.fifo_cnt = q.fifo_cnt + 3'h1;
        end
        // both-edge mode ignores the per-interrupt count
        if (q.cap_mode == CAP_BOTH || q.ipi_cnt == q.cap_ipi) begin
          fire = 1'b1;
          n.ipi_cnt = 2'b00;
        end else begin
          n.ipi_cnt = q.ipi_cnt + 2'b01;
        end
        flag_set[IRQ_CAP_FLAG_BIT] = fire;
      end
    end
    // reading the buffer removes the oldest entry; overrun clears once drained
    pop = rd && (avm_req.address == OFF_CAP_BUF) && q.pop_ok;
    if (pop) begin
      n.rd_ptr = q.rd_ptr + 2'b01;
      n.fifo_cnt = n.fifo_cnt - 3'h1;
      if (n.fifo_cnt == 3'h0) begin
        n.cap_ov = 1'b0;
      end
    end
    // ==========================================================
    // compare channel
    cmp_run = ~(q.cmp_idle & cpu_idle);
    cmp_pick_a = ~q.cmp_tb;
    cmp_cnt = tb_pick(cmp_pick_a, q.tb_cnt);
    if (cmp_run && tb_ticking(cmp_pick_a, q.tb_run)) begin
      case (q.cmp_st)
        CMP_WAIT_RISE: begin
          if (cmp_cnt == q.cmp_pri) begin
            n.pin = 1'b1;
            n.cmp_st = CMP_WAIT_FALL;
          end
        end
        CMP_WAIT_FALL: begin
          if (cmp_cnt == q.cmp_sec) begin
            n.pin = 1'b0;
            flag_set[IRQ_CMP_FLAG_BIT] = 1'b1;
            n.cmp_st = (q.cmp_mode == CMP_CONT) ?
              CMP_WAIT_RISE : CMP_DONE;
          end
        end
        CMP_DONE: n.pin = 1'b0;
        default: n.pin = 1'b0;
      endcase
    end
    // ==========================================================
    // register writes
    if (wr) begin
      case (avm_req.address)
        OFF_CAP_CTRL: begin
          n.cap_idle = avm_req.writedata[CAP_IDLE_BIT];
          n.cap_tb = avm_req.writedata[CAP_TB_BIT];
          n.cap_ipi = avm_req.writedata[CAP_IPI_LSB +: 2];
          n.cap_mode = avm_req.writedata[2:0];
          if (avm_req.writedata[2:0] == CAP_OFF || avm_req.writedata[2:0] == CAP_UNUSED) begin
            n.fifo_cnt = 3'h0;
            n.cap_ov = 1'b0;
            n.pre_cnt = 4'h0;
            n.ipi_cnt = 2'b00;
          end
        end
        OFF_CMP_CTRL: begin
          n.cmp_idle = avm_req.writedata[CMP_IDLE_BIT];
          n.cmp_tb = avm_req.writedata[CMP_TB_BIT];
          n.cmp_mode = avm_req.writedata[2:0];
          n.pin = 1'b0;
          // any write of a pulse mode rearms, timer state untouched
          if (avm_req.writedata[2:0] == CMP_ONESHOT || avm_req.writedata[2:0] == CMP_CONT) begin
            n.cmp_st = CMP_WAIT_RISE;
          end else begin
            n.cmp_st = CMP_IDLE;
          end
        end
        OFF_CMP_PRI: n.cmp_pri = avm_req.writedata[15:0];
        OFF_CMP_SEC: n.cmp_sec = avm_req.writedata[15:0];
        OFF_IRQ: begin
          flag_clr = avm_req.writedata[IRQ_CAP_FLAG_BIT +: 2];
          n.en = avm_req.writedata[IRQ_CAP_EN_BIT +: 2];
        end
        OFF_TB_A_CNT: n.tb_cnt[0] = avm_req.writedata[15:0];
        OFF_TB_A_PER: n.tb_per[0] = avm_req.writedata[15:0];
        OFF_TB_B_CNT: n.tb_cnt[1] = avm_req.writedata[15:0];
        OFF_TB_B_PER: n.tb_per[1] = avm_req.writedata[15:0];
        OFF_TB_RUN: n.tb_run = avm_req.writedata[1:0];
        default: n.tb_run = n.tb_run;
      endcase
    end
    // set beats clear so no event is lost
    n.flag = (q.flag & ~flag_clr) | flag_set;
    n.irq = n.flag & n.en;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q <= '0;
      q.wait_q <= 1'b1;
    end else if (clk_en) begin
      q <= n;
    end
  end

  assign avm_rsp.readdata = q.rdata;
  assign avm_rsp.waitrequest = q.wait_q;
  assign compare_output_pin = q.pin;
  assign capture_irq = q.irq[IRQ_CAP_FLAG_BIT];
  assign compare_irq = q.irq[IRQ_CMP_FLAG_BIT];

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_fall_match;
    clk_en && !wr && q.cmp_st == CMP_WAIT_FALL && cmp_run
      && tb_ticking(cmp_pick_a, q.tb_run) && cmp_cnt == q.cmp_sec;
  endsequence
  sequence s_pin_down_flagged;
    !compare_output_pin && q.flag[IRQ_CMP_FLAG_BIT];
  endsequence

  property p_idle_freeze;
    clk_en && q.cap_idle && cpu_idle && q.cap_mode != CAP_WAKE && !pop && !wr
      |=> q.fifo_cnt == $past(q.fifo_cnt);
  endproperty
  a_idle_freeze: assert property (p_idle_freeze) else $error("idle capture moved");

  property p_tb_sel;
    clk_en && ev && q.fifo_cnt != FIFO_DEPTH && q.cap_tb && !wr
      |=> q.fifo[$past(q.rd_ptr + q.fifo_cnt[1:0])] == $past(q.tb_cnt[0]);
  endproperty
  a_tb_sel: assert property (p_tb_sel) else $error("capture not timebase A");

  property p_overrun;
    clk_en && ev && q.fifo_cnt == FIFO_DEPTH && !pop && !wr
      |=> q.cap_ov && q.fifo_cnt == FIFO_DEPTH;
  endproperty
  a_overrun: assert property (p_overrun) else $error("full capture did not overrun");

  property p_off_mode;
    clk_en && (q.cap_mode == CAP_OFF || q.cap_mode == CAP_UNUSED) && !wr
      |=> q.fifo_cnt <= $past(q.fifo_cnt);
  endproperty
  a_off_mode: assert property (p_off_mode) else $error("disabled capture stored");

  property p_rise;
    clk_en && !wr && q.cmp_st == CMP_WAIT_RISE && cmp_run
      && tb_ticking(cmp_pick_a, q.tb_run) && cmp_cnt == q.cmp_pri |=> compare_output_pin;
  endproperty
  a_rise: assert property (p_rise) else $error("pin missed primary match");

  property p_fall;
    s_fall_match |=> s_pin_down_flagged;
  endproperty
  a_fall: assert property (p_fall) else $error("secondary match did not end pulse");

  property p_oneshot_done;
    clk_en && q.cmp_st == CMP_DONE && !wr |=> !compare_output_pin [*2];
  endproperty
  a_oneshot_done: assert property (p_oneshot_done) else $error("pulse after done");

  property p_rearm;
    clk_en && wr && avm_req.address == OFF_CMP_CTRL && avm_req.writedata[2:0] == CMP_ONESHOT
      |=> !compare_output_pin && q.cmp_st == CMP_WAIT_RISE;
  endproperty
  a_rearm: assert property (p_rearm) else $error("one-shot write did not rearm low");

  property p_wrap;
    clk_en && q.tb_run[0] && q.tb_cnt[0] == q.tb_per[0] && !wr |=> q.tb_cnt[0] == RESET_VALUE;
  endproperty
  a_wrap: assert property (p_wrap) else $error("timebase A did not wrap");

  property p_write_low;
    clk_en && wr && avm_req.address == OFF_CMP_CTRL |=> !compare_output_pin;
  endproperty
  a_write_low: assert property (p_write_low) else $error("pin high after write");

  property p_cont_flag;
    clk_en && !wr && q.cmp_st == CMP_WAIT_FALL && q.cmp_mode == CMP_CONT && cmp_run
      && tb_ticking(cmp_pick_a, q.tb_run) && cmp_cnt == q.cmp_sec
      |=> q.flag[IRQ_CMP_FLAG_BIT] && q.cmp_st == CMP_WAIT_RISE;
  endproperty
  a_cont_flag: assert property (p_cont_flag) else $error("cont match missed");

  property p_nonempty_bit;
    clk_en && req && q.wait_q && avm_req.address == OFF_CAP_CTRL
      |=> avm_rsp.readdata[CAP_BNE_BIT] == ($past(q.fifo_cnt) != 3'h0);
  endproperty
  a_nonempty_bit: assert property (p_nonempty_bit) else $error("bad nonempty bit");
endmodule : tcp_top

/* File: sim/tcp_partner.sv */
// partner: capture input source and compare output load
`timescale 1ns/10ps
module tcp_partner (
  input wire logic clk_sys,
  output logic capture_input_pin,
  input wire logic compare_output_pin
);
  int rises;
  int width;
  int run;
  // ==========================================================
  // capture input: slow pulses so the sync and filter agree
  initial begin
    capture_input_pin = 1'b0;
    rises = 0;
    width = 0;
    run = 0;
  end
  task automatic pulses(input int n);
    repeat (n) begin
      capture_input_pin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      capture_input_pin <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    // settle time covers the three-flop sync
    repeat (8) @(posedge clk_sys);
  endtask : pulses
  // ==========================================================
  // output load: counts pulses and last high width
  always @(posedge clk_sys) begin
    if (compare_output_pin === 1'b1) begin
      run <= run + 1;
      if (run == 0) rises <= rises + 1;
    end else if (run != 0) begin
      width <= run;
      run <= 0;
    end
  end
endmodule : tcp_partner

/* File: sim/tcp_top_tb.sv */
// testbench: register-level scenarios for the capture and pulse block
`timescale 1ns/10ps
module tcp_top_tb;
  import tcp_pkg::*;
  logic clk_sys, rst_n, clk_en, cpu_idle, cpu_sleep, capture_input_pin;
  logic compare_output_pin, capture_irq, compare_irq;
  tcp_avm_req_t avm_req;
  tcp_avm_rsp_t avm_rsp;
  int num_errors, checked, cycles, r0;
  logic [31:0] rd;
  logic [31:0] r0_codes[2] = '{32'h80, 32'h86};
  // ==========================================================
  // clock, design, partner
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  tcp_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .cpu_idle(cpu_idle),
    .cpu_sleep(cpu_sleep), .capture_input_pin(capture_input_pin), .avm_req(avm_req),
    .avm_rsp(avm_rsp), .compare_output_pin(compare_output_pin), .capture_irq(capture_irq),
    .compare_irq(compare_irq));
  tcp_partner i_partner (.clk_sys(clk_sys), .capture_input_pin(capture_input_pin),
    .compare_output_pin(compare_output_pin));
  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic bus(input logic wr, input logic [5:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    avm_req <= '{read: ~wr, write: wr, address: addr, writedata: wd};
    do begin
      @(posedge clk_sys);
      n++;
    end while (avm_rsp.waitrequest !== 1'b0);
    // fixed latency: seen at the first edge, taken at the second
    chk(n, 32'd2);
    rd = avm_rsp.readdata;
    avm_req <= '0;
    // one free edge so the next request is a fresh one
    @(posedge clk_sys);
  endtask : bus
  task automatic caps(input int n, input logic [15:0] v);
    repeat (n) begin
      bus(1'b0, OFF_CAP_CTRL, 32'h0);
      chk(rd & 32'h18, 32'h08);
      bus(1'b0, OFF_CAP_BUF, 32'h0);
      chk(rd, {16'h0, v});
    end
    bus(1'b0, OFF_CAP_CTRL, 32'h0);
    chk(rd & 32'h18, 32'h0);
  endtask : caps
  // ==========================================================
  // scenarios
  task automatic t_reset;
    chk({31'h0, avm_rsp.waitrequest}, 32'h1);
    bus(1'b0, OFF_CAP_CTRL, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 6'h3c, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, OFF_TB_A_CNT, 32'h1234);
    bus(1'b1, OFF_TB_B_CNT, 32'h5678);
  endtask : t_reset
  task automatic t_modes;
    bus(1'b1, OFF_CAP_CTRL, 32'h83);
    i_partner.pulses(1);
    caps(1, 16'h1234);
    bus(1'b1, OFF_CAP_CTRL, 32'h03);
    i_partner.pulses(1);
    caps(1, 16'h5678);
    bus(1'b1, OFF_CAP_CTRL, 32'h82);
    i_partner.pulses(1);
    caps(1, 16'h1234);
    bus(1'b1, OFF_CAP_CTRL, 32'h81);
    i_partner.pulses(1);
    caps(2, 16'h1234);
    bus(1'b1, OFF_CAP_CTRL, 32'h80);
    bus(1'b1, OFF_CAP_CTRL, 32'h84);
    i_partner.pulses(3);
    caps(0, 16'h0);
    i_partner.pulses(1);
    caps(1, 16'h1234);
    bus(1'b1, OFF_CAP_CTRL, 32'h80);
    bus(1'b1, OFF_CAP_CTRL, 32'h85);
    i_partner.pulses(15);
    caps(0, 16'h0);
    i_partner.pulses(1);
    caps(1, 16'h1234);
    foreach (r0_codes[i]) begin
      bus(1'b1, OFF_CAP_CTRL, r0_codes[i]);
      i_partner.pulses(1);
      caps(0, 16'h0);
    end
  endtask : t_modes
  task automatic t_ovf_irq;
    bus(1'b1, OFF_CAP_CTRL, 32'h83);
    i_partner.pulses(5);
    bus(1'b0, OFF_CAP_CTRL, 32'h0);
    chk(rd & 32'h18, 32'h18);
    repeat (4) bus(1'b0, OFF_CAP_BUF, 32'h0);
    bus(1'b0, OFF_CAP_CTRL, 32'h0);
    chk(rd & 32'h18, 32'h0);
    bus(1'b1, OFF_CAP_CTRL, 32'he3);
    bus(1'b1, OFF_IRQ, 32'h101);
    i_partner.pulses(3);
    chk({31'h0, capture_irq}, 32'h0);
    i_partner.pulses(1);
    chk({31'h0, capture_irq}, 32'h1);
    caps(4, 16'h1234);
    bus(1'b1, OFF_CAP_CTRL, 32'he1);
    bus(1'b1, OFF_IRQ, 32'h101);
    i_partner.pulses(1);
    chk({31'h0, capture_irq}, 32'h1);
    caps(2, 16'h1234);
    bus(1'b1, OFF_CAP_CTRL, 32'h2083);
    cpu_idle <= 1'b1;
    i_partner.pulses(1);
    caps(0, 16'h0);
    bus(1'b1, OFF_CAP_CTRL, 32'h83);
    i_partner.pulses(1);
    caps(1, 16'h1234);
    cpu_idle <= 1'b0;
    cpu_sleep <= 1'b1;
    bus(1'b1, OFF_CAP_CTRL, 32'h87);
    bus(1'b1, OFF_IRQ, 32'h101);
    i_partner.pulses(1);
    chk({31'h0, capture_irq}, 32'h1);
    caps(0, 16'h0);
    cpu_sleep <= 1'b0;
  endtask : t_ovf_irq
  task automatic t_pulse;
    bus(1'b1, OFF_TB_A_PER, 32'd40);
    bus(1'b1, OFF_TB_A_CNT, 32'h0);
    bus(1'b1, OFF_CMP_PRI, 32'd10);
    bus(1'b1, OFF_CMP_SEC, 32'd20);
    bus(1'b1, OFF_CMP_CTRL, {29'h0, CMP_ONESHOT});
    chk({31'h0, compare_output_pin}, 32'h0);
    r0 = i_partner.rises;
    bus(1'b1, OFF_TB_RUN, 32'h1);
    repeat (100) @(posedge clk_sys);
    chk(i_partner.rises - r0, 32'h1);
    chk(i_partner.width, 32'd10);
    bus(1'b0, OFF_IRQ, 32'h0);
    chk(rd & 32'h2, 32'h2);
    chk({31'h0, compare_irq}, 32'h0);
    bus(1'b1, OFF_IRQ, 32'h202);
    r0 = i_partner.rises;
    bus(1'b1, OFF_CMP_CTRL, {29'h0, CMP_ONESHOT});
    repeat (100) @(posedge clk_sys);
    chk(i_partner.rises - r0, 32'h1);
    chk({31'h0, compare_irq}, 32'h1);
    bus(1'b1, OFF_TB_RUN, 32'h0);
    bus(1'b1, OFF_TB_B_PER, 32'd29);
    bus(1'b1, OFF_TB_B_CNT, 32'h0);
    bus(1'b1, OFF_CMP_PRI, 32'd5);
    bus(1'b1, OFF_CMP_SEC, 32'd15);
    bus(1'b1, OFF_CMP_CTRL, 32'h8 | {29'h0, CMP_CONT});
    chk({31'h0, compare_output_pin}, 32'h0);
    bus(1'b1, OFF_IRQ, 32'h202);
    r0 = i_partner.rises;
    bus(1'b1, OFF_TB_RUN, 32'h2);
    repeat (80) @(posedge clk_sys);
    chk(i_partner.rises - r0, 32'h3);
    chk(i_partner.width, 32'd10);
    bus(1'b1, OFF_IRQ, 32'h202);
    repeat (30) @(posedge clk_sys);
    chk({31'h0, compare_irq}, 32'h1);
    // rewrite the mode while a pulse is high: the pin must drop at once
    while (compare_output_pin !== 1'b1) @(posedge clk_sys);
    bus(1'b1, OFF_CMP_CTRL, 32'h8 | {29'h0, CMP_CONT});
    chk({31'h0, compare_output_pin}, 32'h0);
  endtask : t_pulse
  task automatic t_freeze;
    bus(1'b1, OFF_TB_A_PER, 32'hffff);
    bus(1'b1, OFF_TB_A_CNT, 32'h0);
    bus(1'b1, OFF_TB_RUN, 32'h1);
    bus(1'b0, OFF_TB_A_CNT, 32'h0);
    r0 = rd;
    clk_en <= 1'b0;
    repeat (20) @(posedge clk_sys);
    clk_en <= 1'b1;
    bus(1'b0, OFF_TB_A_CNT, 32'h0);
    // three enabled edges lie between the samples, frozen ones add nothing
    chk(rd - r0, 32'd3);
  endtask : t_freeze
  // ==========================================================
  // main sequence and timeout
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    cpu_idle = 1'b0;
    cpu_sleep = 1'b0;
    avm_req = '0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_modes();
    t_ovf_irq();
    t_pulse();
    t_freeze();
    finish_test();
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end
endmodule : tcp_top_tb
